// file: dv/test_uart_pin_function_and_usb_wake.sv
module test_uart_pin_function_and_usb_wake;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, ring = 1'b1, rxp = 1'b1, txb = 1'b0, rxb = 1'b0;
   logic rts = 1'b0, dtr = 1'b0, hdir = 1'b0, wave = 1'b0, quiet = 1'b0;
   logic idv = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [9:0] gin = 10'h3FF;
   logic [15:0] vid = 16'hBEEF, pid = 16'hCAFE;
   logic [31:0] prdata, rd;
   logic pready, pslverr, cts, dsr, act, rwk, req, sus, sa, sb;
   logic [9:0] gout, goe, gpu;
   logic [15:0] dvid, dpid;
   logic [7:0] ncfg, nif;
   int fail_count = 0;
   int num_checks = 0;
   initial begin
      forever #12.5 clk = ~clk;
   end
   upmw_top #(.IDLE_CYC(20), .ENTER_CYC(20), .WAKE_CYC(10), .IND_HALF(4)) uut (
      .CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .GP_IN(gin), .GP_OUT(gout),
      .GP_OE(goe), .GP_PULLUP(gpu), .RING_WAKE_PIN(ring), .RX_PIN(rxp),
      .UART_TX_BUSY(txb), .UART_RX_BUSY(rxb), .UART_RTS(rts), .UART_DTR(dtr),
      .HALF_DUPLEX_DIR(hdir), .CLK_WAVE(wave), .UART_CTS(cts), .UART_DSR(dsr),
      .USB_ACTIVITY(act), .OTP_ID_VALID(idv), .OTP_VID(vid), .OTP_PID(pid),
      .DESC_VID(dvid), .DESC_PID(dpid), .DESC_REMOTE_WAKE(rwk),
      .DESC_NUM_CONFIGS(ncfg), .DESC_NUM_IFACES(nif), .USB_RESUME_REQ(req),
      .USB_SUSPENDED(sus), .USB_STATUS_OUT_A(sa), .USB_STATUS_OUT_B(sb));
   upmw_host_model host (.clk(clk), .rst_n(rst_n), .go_quiet(quiet),
      .resume_req(req), .activity(act));
   task automatic chk(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      if (fail_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         stop_test();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // A wait that runs out of cycles ends the run as a failure.
   task automatic wait_sig(input bit on_req, input logic v, input int lim);
      int n;
      n = 0;
      while ((on_req ? req : sus) !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      if ((on_req ? req : sus) !== v) begin
         fail_count++;
         stop_test();
      end
   endtask
   task automatic ind(input int b);
      int t;
      logic p;
      {rxb, txb} <= (b == 8) ? 2'b01 : 2'b10;
      repeat (8) @(posedge clk);
      for (int k = 0; k < 2; k++) begin
         t = 0;
         repeat (16) begin
            p = gout[b];
            @(posedge clk);
            t += int'(gout[b] != p);
         end
         chk("toggles", t, k ? 0 : 4);
         {rxb, txb} <= 2'b00;
         repeat (8) @(posedge clk);
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk("oe", goe, 0);
      chk("pullup", gpu, 10'h3FF);
      chk("wake attr", rwk, 1);
      chk("counts", {ncfg, nif}, 16'h0101);
      chk("ids", {dpid, dvid}, {uut.DEF_PID, uut.DEF_VID});
      apb(0, 8'h10, 0);
      chk("ctrl", rd, 1);
      apb(0, 8'h1C, 0);
      chk("unmapped", rd, 0);
      idv <= 1'b1;
      repeat (3) @(posedge clk);
      chk("otp ids", {dpid, dvid}, {pid, vid});
      apb(1, 8'h00, 32'h0000_03FC);
      repeat (3) @(posedge clk);
      chk("oe alt", goe, 10'h3E8);
      for (int v = 0; v < 2; v++) begin
         {rts, dtr, hdir, wave} <= {4{v[0]}};
         gin <= {5'h1F, v[0], 1'b1, v[0], 2'h3};
         repeat (4) @(posedge clk);
         chk("pins", {gout[7:5], gout[3]}, {v[0], v[0], ~v[0], ~v[0]});
         chk("cts dsr", {cts, dsr}, {~v[0], ~v[0]});
      end
      apb(1, 8'h10, 32'h0000_0005);
      {rts, hdir} <= 2'b00;
      repeat (4) @(posedge clk);
      chk("auto dir", gout[5], 0);
      ind(8);
      ind(9);
      for (int s = 0; s < 2; s++) begin
         quiet <= 1'b1;
         @(posedge clk);
         quiet <= 1'b0;
         wait_sig(0, 1, 100);
         chk("status", {sa, sb}, 2'b10);
         ring <= 1'b0;
         repeat (4) @(posedge clk);
         chk("ring wake", req, s ? 0 : 1);
         ring <= 1'b1;
         if (s == 1) begin
            chk("still asleep", sus, 1);
            rxp <= 1'b0;
            wait_sig(1, 1, 20);
            chk("rx wake", req, 1);
            rxp <= 1'b1;
         end
         wait_sig(1, 0, 40);
         repeat (4) @(posedge clk);
         chk("awake", sus, 0);
         apb(1, 8'h08, 32'h0000_0002);
         apb(1, 8'h10, 32'h0000_0003);
      end
      stop_test();
   end
endmodule

// file: dv/upmw_host_model.sv
module upmw_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go_quiet,
   input wire logic resume_req,
   output logic activity
);
   timeunit 1ns;
   timeprecision 100ps;
   logic quiet;
   logic req_d;
   logic [2:0] frame;
   // A marker every eight cycles stands in for frame traffic on the bus.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet <= 1'b0;
         req_d <= 1'b0;
         frame <= 3'h0;
         activity <= 1'b0;
      end else begin
         req_d <= resume_req;
         frame <= frame + 3'h1;
         activity <= !quiet && frame == 3'h0;
         if (go_quiet) begin
            quiet <= 1'b1;
         end else if (req_d && !resume_req) begin
            quiet <= 1'b0;
         end
      end
   end
endmodule

// file: dv/upmw_props.sv
module upmw_props #(
   parameter int IDLE_CYC = 20,
   parameter int ENTER_CYC = 20,
   parameter int WAKE_CYC = 10
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic [9:0] GP_OE,
   input wire logic [9:0] GP_PULLUP,
   input wire logic USB_ACTIVITY,
   input wire logic USB_RESUME_REQ,
   input wire logic USB_SUSPENDED,
   input wire logic USB_STATUS_OUT_A,
   input wire logic USB_STATUS_OUT_B,
   input wire logic [7:0] DESC_NUM_CONFIGS,
   input wire logic [7:0] DESC_NUM_IFACES
);
   logic [15:0] idle;
   logic [15:0] req;
   logic seen;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // The idle count saturates so a long quiet spell cannot wrap around.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         idle <= '0;
         req <= '0;
         seen <= 1'b0;
      end else begin
         // A wakeup may end suspend while the bus is still quiet.
         seen <= !USB_ACTIVITY && (seen || USB_SUSPENDED);
         idle <= USB_ACTIVITY ? '0 : idle + 16'(idle != 16'hFFFF);
         req <= USB_RESUME_REQ ? req + 16'h0001 : '0;
      end
   end
   a_pullup_tracks_oe: assert property (GP_PULLUP == ~GP_OE)
      else $error("pull-up is not the inverse of the enable");
   a_one_config: assert property (DESC_NUM_CONFIGS == 8'h01
      && DESC_NUM_IFACES == 8'h01) else $error("descriptor counts wrong");
   a_suspend_not_early: assert property ($rose(USB_SUSPENDED) |->
      idle >= IDLE_CYC + ENTER_CYC - 2) else $error("suspended too early");
   a_suspend_not_late: assert property (idle == IDLE_CYC + ENTER_CYC + 6
      |-> USB_SUSPENDED || seen) else $error("suspend not reached in time");
   a_status_follows: assert property ($changed(USB_SUSPENDED) |->
      $changed(USB_STATUS_OUT_A) && $changed(USB_STATUS_OUT_B))
      else $error("status outputs lag suspend");
   a_resume_after_susp: assert property ($rose(USB_RESUME_REQ) |->
      $past(USB_SUSPENDED, 2)) else $error("resume without suspend");
   a_resume_not_susp: assert property (USB_RESUME_REQ |->
      !USB_SUSPENDED) else $error("resume while still suspended");
   a_resume_length: assert property ($fell(USB_RESUME_REQ) |->
      req == WAKE_CYC) else $error("resume request length wrong");
   c_suspend: cover property ($rose(USB_SUSPENDED));
   c_resume: cover property ($rose(USB_RESUME_REQ));
   c_alt_out: cover property ($rose(GP_OE[8]));
endmodule

bind upmw_top upmw_props #(.IDLE_CYC(IDLE_CYC), .ENTER_CYC(ENTER_CYC),
   .WAKE_CYC(WAKE_CYC)) u_props (.CLK(CLK), .RESET_N(RESET_N),
   .GP_OE(GP_OE), .GP_PULLUP(GP_PULLUP), .USB_ACTIVITY(USB_ACTIVITY),
   .USB_RESUME_REQ(USB_RESUME_REQ), .USB_SUSPENDED(USB_SUSPENDED),
   .USB_STATUS_OUT_A(USB_STATUS_OUT_A), .USB_STATUS_OUT_B(USB_STATUS_OUT_B),
   .DESC_NUM_CONFIGS(DESC_NUM_CONFIGS), .DESC_NUM_IFACES(DESC_NUM_IFACES));

// file: logic/upmw_ind_if.sv
interface upmw_ind_if;
   logic busy;
   logic tick;
   logic level;
   modport src (output busy, input tick);
   modport ind (input busy, tick, output level);
endinterface

// file: logic/upmw_indicator.sv
module upmw_indicator (
   input wire logic clk,
   input wire logic rst_n,
   upmw_ind_if.ind ind
);
   typedef struct packed {
      logic level;
   } upmw_ind_st_t;
   upmw_ind_st_t q;
   upmw_ind_st_t next_q;
   always_comb begin
      next_q = q;
      // Idle holds the level rather than parking it low.
      if (ind.busy && ind.tick) begin
         next_q.level = ~q.level;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
   assign ind.level = q.level;
endmodule

// file: logic/upmw_pkg.sv
package upmw_pkg;
   typedef enum logic [1:0] {
      UPMW_ACTIVE = 2'b00,
      UPMW_ENTER = 2'b01,
      UPMW_SUSP = 2'b10,
      UPMW_WAKE = 2'b11
   } upmw_usb_t;
endpackage

// file: logic/upmw_regs.svh
`ifndef UPMW_REGS_SVH
`define UPMW_REGS_SVH
`define UPMW_CLK_HZ 40000000
`define UPMW_IND_HZ 10
`define UPMW_IND_HALF (`UPMW_CLK_HZ / (2 * `UPMW_IND_HZ))
`define UPMW_IDLE_MS 3
`define UPMW_IDLE_CYC (`UPMW_CLK_HZ / 1000 * `UPMW_IDLE_MS)
`define UPMW_ENTER_MS 7
`define UPMW_ENTER_CYC (`UPMW_CLK_HZ / 1000 * `UPMW_ENTER_MS)
`define UPMW_WAKE_US 5000
`define UPMW_WAKE_CYC (`UPMW_CLK_HZ / 1000000 * `UPMW_WAKE_US)
`define UPMW_A_MODE 8'h00
`define UPMW_A_GPOUT 8'h04
`define UPMW_A_GPDIR 8'h08
`define UPMW_A_GPIN 8'h0C
`define UPMW_A_CTRL 8'h10
`define UPMW_A_STAT 8'h14
`define UPMW_A_IDS 8'h18
`define UPMW_MODE_RST 10'h000
`define UPMW_CTRL_RST 6'h01
`define UPMW_C_RWAKE_ATTR 0
`define UPMW_C_RX_WAKE 1
`define UPMW_C_RTS_AUTO 2
`define UPMW_C_STA_POL 3
`define UPMW_C_STB_POL 4
`define UPMW_C_CLK_PULSE 5
`define UPMW_NPINS 10
`endif

// file: logic/upmw_top.sv
// How it works
// - After reset every multipurpose pin is an input with pull-up.
// - Transmit indicator on gp_pin_8 toggles at ten hertz while sending.
// - gp_pin_7 alternate drives the half-duplex transceiver enable.
// - gp_pin_6 alternate outputs a clock waveform or a pulse.
// - gp_pin_4 alternate is clear-to-send input, asserted when low.
// - gp_pin_5 alternate drives request-to-send low or auto direction.
// - gp_pin_2 alternate is data-set-ready input, asserted when low.
// - gp_pin_3 alternate drives active-low terminal-ready push-pull.
// - One control endpoint, one configuration, one UART interface.
// - Suspend begins after three milliseconds without bus activity.
// - Suspended state is reached within the next seven milliseconds.
// - Falling edge on ring/wake pin while suspended requests wakeup.
// - Remote wakeup capability is advertised by default.
// - Ring/wake pin wakes only while configured as an input.
// - Receive data pin wakes the host when its option is enabled.
// - Vendor and product identifiers come from fields or defaults.
// - Receive indicator on gp_pin_9 toggles at ten hertz while receiving.
// - Status output a is high while suspended by default.
// - Status output b is low while suspended by default.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`include "upmw_regs.svh"
module upmw_top
   import upmw_pkg::*;
#(
   parameter int IDLE_CYC = `UPMW_IDLE_CYC,
   parameter int ENTER_CYC = `UPMW_ENTER_CYC,
   parameter int WAKE_CYC = `UPMW_WAKE_CYC,
   parameter int IND_HALF = `UPMW_IND_HALF,
   // Identifier defaults are arbitrary values.
   parameter logic [15:0] DEF_VID = 16'h1234,
   parameter logic [15:0] DEF_PID = 16'h5678
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [9:0] GP_IN,
   output logic [9:0] GP_OUT,
   output logic [9:0] GP_OE,
   output logic [9:0] GP_PULLUP,
   input wire logic RING_WAKE_PIN,
   input wire logic RX_PIN,
   input wire logic UART_TX_BUSY,
   input wire logic UART_RX_BUSY,
   input wire logic UART_RTS,
   input wire logic UART_DTR,
   input wire logic HALF_DUPLEX_DIR,
   input wire logic CLK_WAVE,
   output logic UART_CTS,
   output logic UART_DSR,
   input wire logic USB_ACTIVITY,
   input wire logic OTP_ID_VALID,
   input wire logic [15:0] OTP_VID,
   input wire logic [15:0] OTP_PID,
   output logic [15:0] DESC_VID,
   output logic [15:0] DESC_PID,
   output logic DESC_REMOTE_WAKE,
   output logic [7:0] DESC_NUM_CONFIGS,
   output logic [7:0] DESC_NUM_IFACES,
   output logic USB_RESUME_REQ,
   output logic USB_SUSPENDED,
   output logic USB_STATUS_OUT_A,
   output logic USB_STATUS_OUT_B
);
   localparam int TW = 32;
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   typedef struct packed {
      logic [9:0] mode;
      logic [9:0] gp_out;
      logic [9:0] gp_dir;
      logic [5:0] ctrl;
      logic [9:0] pin_out;
      logic [9:0] pin_oe;
      logic cts;
      logic dsr;
      upmw_usb_t usb;
      logic [TW-1:0] cnt;
      logic [TW-1:0] ind_cnt;
      logic ring_d;
      logic rx_d;
      logic resume;
      logic sta;
      logic stb;
      logic [15:0] vid;
      logic [15:0] pid;
      logic [31:0] rdata;
      logic pulse;
   } upmw_st_t;
   upmw_st_t q;
   upmw_st_t next_q;

   upmw_ind_if tx_if ();
   upmw_ind_if rx_if ();
   upmw_indicator u_tx_ind (
      .clk(CLK),
      .rst_n(rst_n),
      .ind(tx_if.ind)
   );
   upmw_indicator u_rx_ind (
      .clk(CLK),
      .rst_n(rst_n),
      .ind(rx_if.ind)
   );

   function automatic logic sel(input logic [9:0] m, input int unsigned i);
      sel = m[i];
   endfunction

   logic tick;
   logic wr;
   logic rd_en;
   assign tick = (q.ind_cnt == TW'(IND_HALF - 1));
   assign tx_if.busy = UART_TX_BUSY;
   assign tx_if.tick = tick;
   assign rx_if.busy = UART_RX_BUSY;
   assign rx_if.tick = tick;
   assign wr = PSEL && PENABLE && PWRITE;
   assign rd_en = PSEL && !PENABLE && !PWRITE;

   always_comb begin
      logic ring_fall;
      logic rx_fall;
      logic wake_ok;
      logic susp;
      ring_fall = 1'b0;
      rx_fall = 1'b0;
      wake_ok = 1'b0;
      susp = 1'b0;
      next_q = q;
      next_q.ring_d = RING_WAKE_PIN;
      next_q.rx_d = RX_PIN;
      next_q.ind_cnt = tick ? '0 : q.ind_cnt + TW'(1);
      if (wr) begin
         case (PADDR)
            `UPMW_A_MODE: next_q.mode = PWDATA[9:0];
            `UPMW_A_GPOUT: next_q.gp_out = PWDATA[9:0];
            `UPMW_A_GPDIR: next_q.gp_dir = PWDATA[9:0];
            `UPMW_A_CTRL: next_q.ctrl = PWDATA[5:0];
            default: next_q.ctrl = q.ctrl;
         endcase
      end
      if (rd_en) begin
         case (PADDR)
            `UPMW_A_MODE: next_q.rdata = {22'h00_0000, q.mode};
            `UPMW_A_GPOUT: next_q.rdata = {22'h00_0000, q.gp_out};
            `UPMW_A_GPDIR: next_q.rdata = {22'h00_0000, q.gp_dir};
            `UPMW_A_GPIN: next_q.rdata = {22'h00_0000, GP_IN};
            `UPMW_A_CTRL: next_q.rdata = {26'h000_0000, q.ctrl};
            `UPMW_A_STAT: next_q.rdata = {28'h000_0000, q.sta, q.stb, q.usb};
            `UPMW_A_IDS: next_q.rdata = {q.pid, q.vid};
            default: next_q.rdata = 32'h0000_0000;
         endcase
      end
      // Default is GPIO: output register drives only when direction is set.
      next_q.pin_out = q.gp_out;
      next_q.pin_oe = q.gp_dir;
      if (sel(q.mode, 8)) begin
         next_q.pin_out[8] = tx_if.level;
         next_q.pin_oe[8] = 1'b1;
      end
      if (sel(q.mode, 9)) begin
         next_q.pin_out[9] = rx_if.level;
         next_q.pin_oe[9] = 1'b1;
      end
      if (sel(q.mode, 7)) begin
         next_q.pin_out[7] = HALF_DUPLEX_DIR;
         next_q.pin_oe[7] = 1'b1;
      end
      next_q.pulse = CLK_WAVE;
      if (sel(q.mode, 6)) begin
         // Pulse mode emits one cycle per rising edge of the wave.
         next_q.pin_out[6] = q.ctrl[`UPMW_C_CLK_PULSE] ?
            (CLK_WAVE && !q.pulse) : CLK_WAVE;
         next_q.pin_oe[6] = 1'b1;
      end
      if (sel(q.mode, 5)) begin
         next_q.pin_out[5] = q.ctrl[`UPMW_C_RTS_AUTO] ?
            HALF_DUPLEX_DIR : !UART_RTS;
         next_q.pin_oe[5] = 1'b1;
      end
      if (sel(q.mode, 4)) begin
         next_q.pin_oe[4] = 1'b0;
      end
      next_q.cts = sel(q.mode, 4) && !GP_IN[4];
      if (sel(q.mode, 3)) begin
         next_q.pin_out[3] = !UART_DTR;
         next_q.pin_oe[3] = 1'b1;
      end
      if (sel(q.mode, 2)) begin
         next_q.pin_oe[2] = 1'b0;
      end
      next_q.dsr = sel(q.mode, 2) && !GP_IN[2];
      // Ring/wake is a dedicated input; mode bit 1 or direction bit 1 releases it.
      wake_ok = !sel(q.mode, 1) && !q.gp_dir[1];
      ring_fall = q.ring_d && !RING_WAKE_PIN && wake_ok;
      rx_fall = q.rx_d && !RX_PIN && q.ctrl[`UPMW_C_RX_WAKE];
      next_q.resume = 1'b0;
      case (q.usb)
         UPMW_ACTIVE: begin
            next_q.cnt = USB_ACTIVITY ? '0 : q.cnt + TW'(1);
            if (!USB_ACTIVITY && q.cnt == TW'(IDLE_CYC - 1)) begin
               next_q.usb = UPMW_ENTER;
               next_q.cnt = '0;
            end
         end
         UPMW_ENTER: begin
            next_q.cnt = q.cnt + TW'(1);
            if (USB_ACTIVITY) begin
               next_q.usb = UPMW_ACTIVE;
               next_q.cnt = '0;
            end else if (q.cnt == TW'(ENTER_CYC - 1)) begin
               next_q.usb = UPMW_SUSP;
               next_q.cnt = '0;
            end
         end
         UPMW_SUSP: begin
            next_q.cnt = '0;
            if (USB_ACTIVITY) begin
               next_q.usb = UPMW_ACTIVE;
            end else if ((ring_fall || rx_fall) &&
                         q.ctrl[`UPMW_C_RWAKE_ATTR]) begin
               next_q.usb = UPMW_WAKE;
            end
         end
         UPMW_WAKE: begin
            next_q.resume = 1'b1;
            next_q.cnt = q.cnt + TW'(1);
            if (q.cnt == TW'(WAKE_CYC - 1)) begin
               next_q.usb = UPMW_ACTIVE;
               next_q.cnt = '0;
            end
         end
         default: next_q.usb = UPMW_ACTIVE;
      endcase
      susp = (next_q.usb == UPMW_SUSP);
      next_q.sta = susp ^ q.ctrl[`UPMW_C_STA_POL];
      next_q.stb = !susp ^ q.ctrl[`UPMW_C_STB_POL];
      next_q.vid = OTP_ID_VALID ? OTP_VID : DEF_VID;
      next_q.pid = OTP_ID_VALID ? OTP_PID : DEF_PID;
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.mode <= `UPMW_MODE_RST;
         q.ctrl <= `UPMW_CTRL_RST;
         q.ring_d <= 1'b1;
         q.rx_d <= 1'b1;
         q.stb <= 1'b1;
         q.vid <= 16'h0000;
         q.pid <= 16'h0000;
      end else begin
         q <= next_q;
      end
   end

   assign PRDATA = q.rdata;
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;
   assign GP_OUT = q.pin_out;
   assign GP_OE = q.pin_oe;
   assign GP_PULLUP = ~q.pin_oe;
   assign UART_CTS = q.cts;
   assign UART_DSR = q.dsr;
   assign DESC_VID = q.vid;
   assign DESC_PID = q.pid;
   assign DESC_REMOTE_WAKE = q.ctrl[`UPMW_C_RWAKE_ATTR];
   assign DESC_NUM_CONFIGS = 8'h01;
   assign DESC_NUM_IFACES = 8'h01;
   assign USB_RESUME_REQ = q.resume;
   assign USB_SUSPENDED = (q.usb == UPMW_SUSP);
   assign USB_STATUS_OUT_A = q.sta;
   assign USB_STATUS_OUT_B = q.stb;
endmodule
